// file: verilog/ebs_pkg.sv
// Constants and types of the external brake sequencer.
// Assumes a 20 MHz control clock and settings held stable while running.
//
// Function
// - Sequencing acts only when brake control is enabled; default disabled.
// - Selection offers disabled, enabled with DC injection, enabled without.
// - On run, accelerate only to release frequency and hold there.
// - At release frequency wait release time, then assert brake release.
// - Current below release threshold at release time: trip, brake error.
// - Confirmation assigned: hold frequency, wait up to confirmation time.
// - Confirmation not active within confirmation time: trip, brake error.
// - Confirmation unassigned: skip its wait, go to acceleration wait.
// - After confirmation or release, wait acceleration time, then speed up.
// - Run removed: decelerate to braking frequency, then drop brake release.
// - Confirmation assigned: hold until it drops, at most confirmation time.
// - Confirmation not inactive within confirmation time: trip, brake error.
// - After that, wait stopping time, then decelerate to zero.
// - Four wait timers accept 0 to 5 s in 0.01 s steps.
// - Release and braking frequencies accept 0 to 400 Hz, 0.01 Hz steps.
// - Release current threshold 0 to 3.2 times rated, default rated.
// - Release and error outputs go to general output terminals.
// - In position control, apply brake only when positioning completes.
package ebs_pkg;
  // ===========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TIME_STEP_NS  = 10_000_000;
  localparam int unsigned TICK_CYCLES   = TIME_STEP_NS / CLK_PERIOD_NS;

  // ===========================================================
  // Setting widths and limits
  localparam int unsigned TW = 10;
  localparam int unsigned FW = 16;
  localparam int unsigned CW = 9;
  localparam logic [TW-1:0] WAIT_MAX    = 10'h1F4;
  localparam logic [FW-1:0] FREQ_MAX    = 16'h9C40;
  localparam logic [CW-1:0] CUR_MAX     = 9'h140;
  localparam logic [CW-1:0] CUR_RATED   = 9'h064;
  localparam logic [FW-1:0] FREQ_ZERO   = 16'h0000;

  // ===========================================================
  // Brake control selection codes
  localparam logic [1:0] SEL_OFF    = 2'h0;
  localparam logic [1:0] SEL_ON_DC  = 2'h1;
  localparam logic [1:0] SEL_ON_NDC = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ACC_REL, ST_WAIT_REL, ST_CONF_ON, ST_WAIT_ACC, ST_RUN,
    ST_POS_WAIT, ST_DEC_BRK, ST_CONF_OFF, ST_WAIT_STOP, ST_DEC_ZERO,
    ST_TRIP
  } ebs_state_t;
endpackage

// file: verilog/ebs_tmr_if.sv
// Wait timer link between the sequencer and its timer.
// Assumes both ends share the control clock.
`timescale 1ns/1ps
interface ebs_tmr_if;
  logic                 clear;
  logic [ebs_pkg::TW-1:0] limit;
  logic                 done;
  modport ctl (output clear, output limit, input done);
  modport tmr (input clear, input limit, output done);
endinterface

// file: verilog/ebs_sync.sv
// Two flip-flop synchroniser for a pin level.
// Assumes the pin is asynchronous to i_clk.
`timescale 1ns/1ps
module ebs_sync (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;

  always_comb begin
    meta_next = i_reset ? 1'b0 : i_async;
    sync_next = i_reset ? 1'b0 : meta_reg;
  end

  always_ff @(posedge i_clk) begin
    meta_reg <= meta_next;
    sync_reg <= sync_next;
  end

  assign o_sync = sync_reg;
endmodule

// file: verilog/ebs_timer.sv
// Wait timer counting 0.01 s steps while clear is low.
// Assumes the limit is already clamped by the sequencer.
`timescale 1ns/1ps
module ebs_timer #(
  parameter int unsigned P_TICK_CYCLES = ebs_pkg::TICK_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_reset,
  ebs_tmr_if.tmr    tmr
);
  import ebs_pkg::*;

  logic [17:0]   pre_reg;
  logic [17:0]   pre_next;
  logic [TW-1:0] cnt_reg;
  logic [TW-1:0] cnt_next;
  logic          tick;

  assign tick = (pre_reg == 18'(P_TICK_CYCLES - 1));

  always_comb begin
    pre_next = tick ? 18'h0_0000 : pre_reg + 18'h0_0001;
    cnt_next = cnt_reg;
    if (tick && !tmr.done) begin
      cnt_next = cnt_reg + 10'h001;
    end
    if (i_reset || tmr.clear) begin
      pre_next = 18'h0_0000;
      cnt_next = 10'h000;
    end
  end

  always_ff @(posedge i_clk) begin
    pre_reg <= pre_next;
    cnt_reg <= cnt_next;
  end

  // Zero setting ends the wait at once
  assign tmr.done = (cnt_reg >= tmr.limit);
endmodule

// file: verilog/ebs_top.sv
// External brake sequencer: drives the frequency target, brake release
// and brake error of the drive. Assumes a ramp generator on the same clock
// follows o_freq_target and reports i_output_freq and i_output_current.
`timescale 1ns/1ps
module ebs_top #(
  parameter int unsigned P_TICK_CYCLES = ebs_pkg::TICK_CYCLES
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_reset,
  input  wire logic                 i_run,
  input  wire logic [1:0]           i_brake_sel,
  input  wire logic                 i_confirm_assigned,
  input  wire logic                 i_brake_confirm_in,
  input  wire logic                 i_position_mode,
  input  wire logic                 i_position_done,
  input  wire logic [ebs_pkg::TW-1:0] i_wait_release,
  input  wire logic [ebs_pkg::TW-1:0] i_wait_accel,
  input  wire logic [ebs_pkg::TW-1:0] i_wait_stop,
  input  wire logic [ebs_pkg::TW-1:0] i_wait_confirm,
  input  wire logic [ebs_pkg::FW-1:0] i_release_freq,
  input  wire logic [ebs_pkg::FW-1:0] i_braking_freq,
  input  wire logic [ebs_pkg::FW-1:0] i_command_freq,
  input  wire logic [ebs_pkg::CW-1:0] i_release_current,
  input  wire logic [ebs_pkg::CW-1:0] i_output_current,
  input  wire logic [ebs_pkg::FW-1:0] i_output_freq,
  output logic [ebs_pkg::FW-1:0]      o_freq_target,
  output logic                        o_output_on,
  output logic                        o_brake_release_out,
  output logic                        o_brake_error_out,
  output logic                        o_dc_inject,
  output logic [3:0]                  o_state
);
  import ebs_pkg::*;

  // ===========================================================
  // Settings clamped to their legal ranges
  logic [TW-1:0] w_rel;
  logic [TW-1:0] w_acc;
  logic [TW-1:0] w_stp;
  logic [TW-1:0] w_cnf;
  logic [FW-1:0] f_rel;
  logic [FW-1:0] f_brk;
  logic [CW-1:0] c_rel;
  logic          enabled;
  logic          conf_s;
  logic          cur_ok;

  assign w_rel = (i_wait_release > WAIT_MAX) ? WAIT_MAX :
                 i_wait_release;
  assign w_acc = (i_wait_accel > WAIT_MAX) ? WAIT_MAX :
                 i_wait_accel;
  assign w_stp = (i_wait_stop > WAIT_MAX) ? WAIT_MAX :
                 i_wait_stop;
  assign w_cnf = (i_wait_confirm > WAIT_MAX) ? WAIT_MAX :
                 i_wait_confirm;
  assign f_rel = (i_release_freq > FREQ_MAX) ? FREQ_MAX :
                 i_release_freq;
  assign f_brk = (i_braking_freq > FREQ_MAX) ? FREQ_MAX :
                 i_braking_freq;
  assign c_rel = (i_release_current > CUR_MAX) ? CUR_MAX :
                 i_release_current;
  // Unknown selection code treated as disabled
  assign enabled = (i_brake_sel == SEL_ON_DC) ||
                   (i_brake_sel == SEL_ON_NDC);
  assign cur_ok  = (i_output_current >= c_rel);

  // ===========================================================
  // Pin synchroniser and wait timer
  ebs_tmr_if tmr ();

  ebs_sync u_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_async (i_brake_confirm_in),
    .o_sync  (conf_s)
  );

  ebs_timer #(
    .P_TICK_CYCLES (P_TICK_CYCLES)
  ) u_timer (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .tmr     (tmr)
  );

  // ===========================================================
  // Sequencer
  ebs_state_t    state_reg;
  ebs_state_t    state_next;
  logic [FW-1:0] freq_reg;
  logic [FW-1:0] freq_next;
  logic          on_reg;
  logic          on_next;
  logic          rel_reg;
  logic          rel_next;
  logic          err_reg;
  logic          err_next;
  logic          dc_reg;
  logic          dc_next;

  // Timer restarts on every state change
  always_comb begin
    tmr.clear = (state_next != state_reg);
    case (state_reg)
      ST_WAIT_REL:  tmr.limit = w_rel;
      ST_WAIT_ACC:  tmr.limit = w_acc;
      ST_WAIT_STOP: tmr.limit = w_stp;
      default:      tmr.limit = w_cnf;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (i_run && enabled) begin
          state_next = ST_ACC_REL;
        end
      end
      ST_ACC_REL: begin
        if (!i_run) begin
          state_next = ST_DEC_ZERO;
        end else if (i_output_freq >= f_rel) begin
          state_next = ST_WAIT_REL;
        end
      end
      ST_WAIT_REL: begin
        if (!i_run) begin
          state_next = ST_DEC_ZERO;
        end else if (tmr.done) begin
          if (!cur_ok) begin
            state_next = ST_TRIP;
          end else if (i_confirm_assigned) begin
            state_next = ST_CONF_ON;
          end else begin
            state_next = ST_WAIT_ACC;
          end
        end
      end
      ST_CONF_ON: begin
        if (conf_s) begin
          state_next = ST_WAIT_ACC;
        end else if (tmr.done) begin
          state_next = ST_TRIP;
        end
      end
      ST_WAIT_ACC: begin
        if (tmr.done) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!i_run) begin
          state_next = i_position_mode ? ST_POS_WAIT : ST_DEC_BRK;
        end
      end
      ST_POS_WAIT: begin
        // Positioning owns the speed; brake closes at its end
        if (i_position_done) begin
          state_next = i_confirm_assigned ? ST_CONF_OFF
                                          : ST_WAIT_STOP;
        end
      end
      ST_DEC_BRK: begin
        if (i_output_freq <= f_brk) begin
          state_next = i_confirm_assigned ? ST_CONF_OFF
                                          : ST_WAIT_STOP;
        end
      end
      ST_CONF_OFF: begin
        if (!conf_s) begin
          state_next = ST_WAIT_STOP;
        end else if (tmr.done) begin
          state_next = ST_TRIP;
        end
      end
      ST_WAIT_STOP: begin
        if (tmr.done) begin
          state_next = ST_DEC_ZERO;
        end
      end
      ST_DEC_ZERO: begin
        if (i_output_freq == FREQ_ZERO) begin
          state_next = ST_IDLE;
        end
      end
      ST_TRIP: state_next = ST_TRIP;
      default: state_next = ST_IDLE;
    endcase
    if (i_reset) begin
      state_next = ST_IDLE;
    end
  end

  // Outputs follow the next state so they align with state_reg
  always_comb begin
    freq_next = FREQ_ZERO;
    on_next   = 1'b1;
    rel_next  = 1'b0;
    err_next  = 1'b0;
    dc_next   = 1'b0;
    case (state_next)
      ST_IDLE: begin
        // Disabled: plain drive, no brake handling
        on_next   = i_run || (i_output_freq != FREQ_ZERO);
        freq_next = i_run ? i_command_freq : FREQ_ZERO;
      end
      ST_ACC_REL, ST_WAIT_REL: freq_next = f_rel;
      ST_CONF_ON, ST_WAIT_ACC: begin
        freq_next = f_rel;
        rel_next  = 1'b1;
      end
      ST_RUN, ST_POS_WAIT: begin
        freq_next = i_command_freq;
        rel_next  = 1'b1;
      end
      ST_DEC_BRK: begin
        freq_next = f_brk;
        rel_next  = 1'b1;
      end
      ST_CONF_OFF, ST_WAIT_STOP: freq_next = i_output_freq;
      ST_DEC_ZERO: freq_next = FREQ_ZERO;
      ST_TRIP: begin
        on_next  = 1'b0;
        err_next = 1'b1;
      end
      default: on_next = 1'b0;
    endcase
    // Zero reached in the final ramp: one-cycle DC hold as state goes idle
    dc_next = (state_reg == ST_DEC_ZERO) && (state_next == ST_IDLE) &&
              (i_brake_sel == SEL_ON_DC) && !i_run;
    if (i_reset) begin
      freq_next = FREQ_ZERO;
      on_next   = 1'b0;
      rel_next  = 1'b0;
      err_next  = 1'b0;
      dc_next   = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    state_reg <= state_next;
    freq_reg  <= freq_next;
    on_reg    <= on_next;
    rel_reg   <= rel_next;
    err_reg   <= err_next;
    dc_reg    <= dc_next;
  end

  assign o_freq_target       = freq_reg;
  assign o_output_on         = on_reg;
  assign o_brake_release_out = rel_reg;
  assign o_brake_error_out   = err_reg;
  assign o_dc_inject         = dc_reg;
  assign o_state             = state_reg;

  // ===========================================================
  // Assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_trip_latched: assert property (
    o_brake_error_out |=> o_brake_error_out && !o_brake_release_out
                          && !o_output_on)
    else $error("brake error trip not latched");

  a_disabled_no_release: assert property (
    (state_reg == ST_IDLE) |-> !o_brake_release_out)
    else $error("brake release while sequencer idle");

  a_release_needs_current: assert property (
    $rose(o_brake_release_out) |-> $past(i_output_current) >= $past(c_rel))
    else $error("brake released with too little current");

  a_low_current_trip: assert property (
    (state_reg == ST_WAIT_REL && i_run && tmr.done && !cur_ok)
    |=> o_brake_error_out && !o_brake_release_out)
    else $error("low current did not trip");

  a_conf_hold_freq: assert property (
    (state_reg == ST_CONF_ON) |-> o_freq_target == f_rel
                                  && o_brake_release_out)
    else $error("frequency not held while awaiting confirmation");

  a_conf_on_timeout: assert property (
    (state_reg == ST_CONF_ON && tmr.done && !conf_s)
    |=> o_brake_error_out)
    else $error("missing confirmation did not trip");

  a_no_conf_skip: assert property (
    (state_reg == ST_WAIT_REL && i_run && tmr.done && cur_ok
     && !i_confirm_assigned) |=> state_reg == ST_WAIT_ACC)
    else $error("unassigned confirmation not skipped");

  a_brk_freq_release: assert property (
    (state_reg == ST_DEC_BRK) |-> o_brake_release_out
                                  && o_freq_target == f_brk)
    else $error("release dropped before braking frequency");

  a_conf_off_timeout: assert property (
    (state_reg == ST_CONF_OFF && tmr.done && conf_s)
    |=> o_brake_error_out)
    else $error("confirmation stuck on did not trip");

  a_zero_after_stop: assert property (
    (state_reg == ST_WAIT_STOP && tmr.done)
    |=> o_freq_target == FREQ_ZERO && !o_brake_release_out)
    else $error("no deceleration to zero after stopping wait");
endmodule

// file: sim/ebs_brake_model.sv
// Behavioural external brake with its release contact.
// Assumes the release command comes from the sequencer on the same clock.
`timescale 1ns/1ps
module ebs_brake_model #(
  parameter int P_DELAY = 3
) (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_release,
  input  wire logic i_stuck_open,
  input  wire logic i_stuck_closed,
  output logic      o_confirm
);
  // ===========================================================
  // Mechanical delay of the shoe, then contact level
  logic [P_DELAY-1:0] pipe_reg;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pipe_reg  <= '0;
      o_confirm <= 1'b0;
    end else begin
      pipe_reg <= {pipe_reg[P_DELAY-2:0], i_release};
      // Faulty brake: contact never closes, or welds shut
      if (i_stuck_open)
        o_confirm <= 1'b0;
      else if (i_stuck_closed)
        o_confirm <= o_confirm | pipe_reg[P_DELAY-1];
      else
        o_confirm <= pipe_reg[P_DELAY-1];
    end
  end
endmodule

// file: sim/tb.sv
// Self-checking bench of the external brake sequencer.
// Assumes an ideal ramp: output frequency follows the target next cycle.
`timescale 1ns/1ps
module tb;
  import ebs_pkg::*;
  localparam int TK = 4;
  logic          i_clk, i_reset, i_run, i_confirm_assigned, i_position_mode;
  logic          i_position_done, confirm, stk_open, stk_closed, low_cur;
  logic          o_output_on, o_brake_release_out, o_brake_error_out;
  logic          o_dc_inject, rel_seen, dc_seen;
  logic [1:0]    i_brake_sel;
  logic [3:0]    o_state;
  logic [TW-1:0] i_wait_release, i_wait_accel, i_wait_stop, i_wait_confirm;
  logic [FW-1:0] i_release_freq, i_braking_freq, i_command_freq;
  logic [FW-1:0] i_output_freq, o_freq_target;
  logic [CW-1:0] i_release_current, i_output_current;
  logic [31:0]   seed;
  int            error_cnt, checks_done;

  ebs_top #(.P_TICK_CYCLES(TK)) ebs_top_i (.i_clk(i_clk), .i_reset(i_reset),
    .i_run(i_run), .i_brake_sel(i_brake_sel),
    .i_confirm_assigned(i_confirm_assigned), .i_brake_confirm_in(confirm),
    .i_position_mode(i_position_mode), .i_position_done(i_position_done),
    .i_wait_release(i_wait_release), .i_wait_accel(i_wait_accel),
    .i_wait_stop(i_wait_stop), .i_wait_confirm(i_wait_confirm),
    .i_release_freq(i_release_freq), .i_braking_freq(i_braking_freq),
    .i_command_freq(i_command_freq), .i_release_current(i_release_current),
    .i_output_current(i_output_current), .i_output_freq(i_output_freq),
    .o_freq_target(o_freq_target), .o_output_on(o_output_on),
    .o_brake_release_out(o_brake_release_out),
    .o_brake_error_out(o_brake_error_out), .o_dc_inject(o_dc_inject),
    .o_state(o_state));
  ebs_brake_model #(.P_DELAY(2)) ebs_brake_model_i (.i_clk(i_clk),
    .i_reset(i_reset), .i_release(o_brake_release_out),
    .i_stuck_open(stk_open), .i_stuck_closed(stk_closed), .o_confirm(confirm));

  // ===========================================================
  // Clock, ramp and current of the drive
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    i_output_freq    <= o_output_on ? o_freq_target : 16'h0000;
    i_output_current <= low_cur ? 9'h000 : i_release_current + 9'h001;
  end
  always @(negedge i_clk) begin
    if (o_brake_release_out === 1'b1) rel_seen = 1'b1;
    if (o_dc_inject === 1'b1) dc_seen = 1'b1;
  end

  // ===========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int exp_wait(input logic [TW-1:0] w);
    return int'((w > WAIT_MAX) ? WAIT_MAX : w) * TK;
  endfunction
  function automatic logic [FW-1:0] exp_freq(input logic [FW-1:0] f);
    return (f > FREQ_MAX) ? FREQ_MAX : f;
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_st(input logic [3:0] s, output int n);
    n = 0;
    while (o_state !== s && n < 2000) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check("wait_state", o_state, s);
  endtask
  task automatic do_reset();
    @(posedge i_clk);
    i_reset <= 1'b1;
    i_run   <= 1'b0;
    repeat (16) @(posedge i_clk);
    i_reset <= 1'b0;
    #1;
    rel_seen = 1'b0;
    dc_seen  = 1'b0;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Brake settings drawn small so waits stay short
  task automatic pick(input logic [1:0] sel, input logic ca, pos);
    @(posedge i_clk);
    i_brake_sel        <= sel;
    i_confirm_assigned <= ca;
    i_position_mode    <= pos;
    i_position_done    <= 1'b0;
    i_wait_release     <= TW'(rnd() % 4);
    i_wait_accel       <= TW'(rnd() % 4);
    i_wait_stop        <= TW'(rnd() % 4);
    i_wait_confirm     <= TW'(2 + rnd() % 2);
    i_release_freq     <= 16'h0100 + FW'(rnd() % 1024);
    i_braking_freq     <= 16'h0080 + FW'(rnd() % 128);
    i_command_freq     <= 16'h1000 + FW'(rnd() % 4096);
    i_release_current  <= 9'h001 + CW'(rnd() % 320);
  endtask

  // ===========================================================
  // Whole lift cycle
  task automatic lift(input logic [1:0] sel, input logic ca, pos);
    int n;
    pick(sel, ca, pos);
    do_reset();
    // Corner: settings above range must clamp
    if (sel == SEL_ON_DC && ca && !pos) begin
      i_wait_release <= 10'h3FF;
      i_release_freq <= 16'hFFFF;
    end
    i_run <= 1'b1;
    wait_st(ST_WAIT_REL, n);
    check("rel_target", o_freq_target, exp_freq(i_release_freq));
    check("rel_early", o_brake_release_out, 1'b0);
    n = 0;
    while (o_brake_release_out !== 1'b1 && n < 2600) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check("rel_time", n <= exp_wait(i_wait_release) + 2, 1'b1);
    check("rel_min", n + 2 >= exp_wait(i_wait_release), 1'b1);
    check("after_rel", o_state, ca ? ST_CONF_ON : ST_WAIT_ACC);
    if (ca)
      check("conf_hold", o_freq_target, exp_freq(i_release_freq));
    wait_st(ST_WAIT_ACC, n);
    wait_st(ST_RUN, n);
    check("acc_time", n <= exp_wait(i_wait_accel) + 2, 1'b1);
    @(posedge i_clk);
    #1;
    check("run_target", o_freq_target, i_command_freq);
    i_run <= 1'b0;
    if (pos) begin
      repeat (6) @(posedge i_clk);
      #1;
      check("pos_hold", o_brake_release_out, 1'b1);
      i_position_done <= 1'b1;
    end else begin
      wait_st(ST_DEC_BRK, n);
      check("brk_target", o_freq_target, i_braking_freq);
    end
    while (o_brake_release_out === 1'b1 && n < 4000) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    if (!pos)
      check("brk_freq", i_output_freq <= i_braking_freq, 1'b1);
    check("after_drop", o_state,
          ca ? ST_CONF_OFF : ST_WAIT_STOP);
    wait_st(ST_DEC_ZERO, n);
    check("zero_target", o_freq_target, FREQ_ZERO);
    wait_st(ST_IDLE, n);
    check("dc_inject", o_dc_inject, sel == SEL_ON_DC);
    @(posedge i_clk);
    #1;
    check("dc_seen", dc_seen, sel == SEL_ON_DC);
    check("dc_pulse", o_dc_inject, 1'b0);
    check("no_error", o_brake_error_out, 1'b0);
    $display("test lift sel %0d conf %0d pos %0d done", sel, ca, pos);
  endtask

  // Faults: 0 low current, 1 contact never closes, 2 contact welded
  task automatic trip(input int kind);
    int n;
    pick(SEL_ON_NDC, kind != 0 || rnd() % 2 == 0, 1'b0);
    low_cur    <= kind == 0;
    stk_open   <= kind == 1;
    stk_closed <= kind == 2;
    do_reset();
    i_run <= 1'b1;
    if (kind == 2) begin
      wait_st(ST_RUN, n);
      i_run <= 1'b0;
    end
    wait_st(ST_TRIP, n);
    check("err_set", o_brake_error_out, 1'b1);
    check("trip_rel", o_brake_release_out, 1'b0);
    check("trip_out", o_output_on, 1'b0);
    if (kind == 0) check("low_cur_rel", rel_seen, 1'b0);
    i_run <= 1'b1;
    repeat (30) @(posedge i_clk);
    #1;
    check("err_latched", o_brake_error_out, 1'b1);
    check("trip_stays", o_state, ST_TRIP);
    low_cur    <= 1'b0;
    stk_open   <= 1'b0;
    stk_closed <= 1'b0;
    do_reset();
    check("err_cleared", o_brake_error_out, 1'b0);
    $display("test trip %0d done", kind);
  endtask

  // ===========================================================
  // Main sequence and watchdog
  initial begin
    seed = 32'h4cf7_920c;
    {i_reset, i_run, i_confirm_assigned, i_position_mode} = 4'h8;
    {i_position_done, stk_open, stk_closed, low_cur} = 4'h0;
    {rel_seen, dc_seen} = 2'h0;
    i_brake_sel = SEL_OFF;
    {i_wait_release, i_wait_accel, i_wait_stop, i_wait_confirm} = '0;
    {i_release_freq, i_braking_freq, i_command_freq} = '0;
    i_output_freq = 16'h0000;
    i_release_current = CUR_RATED;
    i_output_current = 9'h000;
    error_cnt = 0;
    checks_done = 0;
    for (int s = 0; s < 2; s++) begin
      pick(s == 0 ? SEL_OFF : 2'h3, 1'b0, 1'b0);
      do_reset();
      i_run <= 1'b1;
      repeat (60) @(posedge i_clk);
      #1;
      check("off_idle", o_state, ST_IDLE);
      check("off_rel", rel_seen, 1'b0);
      $display("test selection off done");
    end
    lift(SEL_ON_DC, 1'b1, 1'b0);
    lift(SEL_ON_NDC, 1'b0, 1'b1);
    for (int k = 0; k < 8; k++)
      lift(2'(1 + rnd() % 2), 1'(rnd() % 2), 1'(rnd() % 2));
    for (int k = 0; k < 3; k++)
      trip(k);
    conclude();
  end
  initial begin
    repeat (60000) @(posedge i_clk);
    error_cnt++;
    conclude();
  end
endmodule
